// file: tic_pkg.sv
// Constants, types and helpers shared by the timer interrupt controller files
// Operation
// - Taking an interrupt clears the global enable, blocking further acknowledgment.
// - With global enable clear, requests still set flags but are never acknowledged.
// - A full return stack withholds acknowledgment until a return pops an entry.
// - Acknowledgment pushes only the program counter, then branches to the vector.
// - Timer 0 overflow sets the timer 0 flag at control bit 5.
// - Timer 0 flag, both enables set and stack room give a call to 08h.
// - Acknowledgment clears the serviced source's flag as well as the global enable.
// - Timer 1 mirrors timer 0: enable bit 3, flag bit 6, vector 0ch.
// - Interrupt return pops and sets global enable; plain return only pops.
// - Requests between two phase-two pulses are serviced at the later pulse.
// - Simultaneous requests: timer 0 is served before timer 1.
// - A flag stays set until serviced or cleared by a software write.
// - Control bit 0 is the global enable, one enables acknowledgment.
// - Control bit 2 is the timer 0 enable, one enables that source.
// - Control bits 1, 4 and 7 always read as zero.
// - Every timer source can wake the core from halt.
// - The return stack has eight levels; full means all eight occupied.
// - A flag already set when halt is entered cannot wake the core.
package tic_pkg;
    localparam int              PC_W           = 15;
    localparam int              STACK_DEPTH    = 8;
    localparam int              IDX_W          = 4;
    localparam logic [3:0]      STACK_FULL_CNT = 4'h8;
    localparam logic [7:0]      CTRL_OFS       = 8'h0b;
    localparam int              GLOBAL_BIT     = 0;
    localparam int              T0E_BIT        = 2;
    localparam int              T1E_BIT        = 3;
    localparam int              T0FLAG_BIT     = 5;
    localparam int              T1FLAG_BIT     = 6;
    localparam logic [7:0]      CTRL_RESET     = 8'h00;
    localparam logic [7:0]      CTRL_USED      = 8'h6d;
    localparam logic [7:0]      VEC_TIMER0     = 8'h08;
    localparam logic [7:0]      VEC_TIMER1     = 8'h0c;
    localparam logic [1:0]      SRC_NONE       = 2'h0;
    localparam logic [1:0]      SRC_T0         = 2'h1;
    localparam logic [1:0]      SRC_T1         = 2'h2;

    typedef enum logic {HS_AWAKE = 1'b0, HS_HALTED = 1'b1} tic_halt_t;

    // Controller state, one word
    typedef struct packed {
        logic       globalEn;
        logic       t0En;
        logic       t1En;
        logic       t0Flag;
        logic       t1Flag;
        logic       ackPulse;
        logic [7:0] vector;
        logic [7:0] rdData;
    } tic_ctrl_t;

    // Return stack state
    typedef struct packed {
        logic [STACK_DEPTH-1:0][PC_W-1:0] entry;
        logic [2:0]                       ptr;
        logic [IDX_W-1:0]                 count;
    } tic_stack_t;

    // Halt and wake state
    typedef struct packed {
        tic_halt_t  mode;
        logic [1:0] armed;
        logic       wake;
    } tic_wake_t;

    // Fixed priority: timer 0 first
    function automatic logic [1:0] tic_pick(input logic [1:0] ready);
        tic_pick = ready[0] ? SRC_T0 : (ready[1] ? SRC_T1 : SRC_NONE);
    endfunction : tic_pick

    // Vector of a source
    function automatic logic [7:0] tic_vector(input logic [1:0] src);
        tic_vector = (src == SRC_T0) ? VEC_TIMER0 : VEC_TIMER1;
    endfunction : tic_vector
endpackage : tic_pkg

// file: tic_return_stack.sv
// Eight-level program counter return stack with full indication
`timescale 1ns/1ps
module tic_return_stack
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    // Push and pop
    input  wire logic                     push,
    input  wire logic [tic_pkg::PC_W-1:0] pushPc,
    input  wire logic                     pop,
    // Status
    output logic      [tic_pkg::PC_W-1:0] topPc,
    output logic                          full
);
    import tic_pkg::*;

    tic_stack_t stk_ff;
    tic_stack_t nxt_stk;

    // Overflowing push wraps and loses the oldest entry
    always_comb
    begin
        nxt_stk = stk_ff;
        if (push)
        begin
            nxt_stk.entry[stk_ff.ptr] = pushPc;
            nxt_stk.ptr = stk_ff.ptr + 3'd1;
            if (stk_ff.count != STACK_FULL_CNT)
                nxt_stk.count = stk_ff.count + 4'd1;
        end
        else if (pop && stk_ff.count != 4'd0)
        begin
            nxt_stk.ptr = stk_ff.ptr - 3'd1;
            nxt_stk.count = stk_ff.count - 4'd1;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            stk_ff <= '0;
        else
            stk_ff <= nxt_stk;
    end

    assign topPc = stk_ff.entry[stk_ff.ptr - 3'd1];
    assign full  = (stk_ff.count == STACK_FULL_CNT);

    chk_full_at_eight: assert property (@(posedge clock) disable iff (!reset_n)
        push && !pop && stk_ff.count == 4'd7 |=> full)
        else $error("stack not full after eighth push");
endmodule : tic_return_stack

// file: tic_wake_gate.sv
// Halt tracking and timer wake-up with flags masked at halt entry
`timescale 1ns/1ps
module tic_wake_gate
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Core and flags
    input  wire logic       haltEnter,
    input  wire logic [1:0] flags,
    // Wake
    output logic            halted,
    output logic            wakeUp
);
    import tic_pkg::*;

    tic_wake_t wk_ff;
    tic_wake_t nxt_wk;

    // Only flags clear at entry may wake; a stale flag would wake at once
    always_comb
    begin
        nxt_wk = wk_ff;
        nxt_wk.wake = 1'b0;
        case (wk_ff.mode)
            HS_AWAKE:
            begin
                if (haltEnter)
                begin
                    nxt_wk.mode = HS_HALTED;
                    nxt_wk.armed = ~flags;
                end
            end
            HS_HALTED:
            begin
                if (|(flags & wk_ff.armed))
                begin
                    nxt_wk.mode = HS_AWAKE;
                    nxt_wk.wake = 1'b1;
                end
            end
            default: nxt_wk.mode = HS_AWAKE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            wk_ff <= '0;
        else
            wk_ff <= nxt_wk;
    end

    assign halted = (wk_ff.mode == HS_HALTED);
    assign wakeUp = wk_ff.wake;

    chk_wake_armed: assert property (@(posedge clock) disable iff (!reset_n)
        wakeUp |-> $past(halted) && |($past(flags) & $past(wk_ff.armed)))
        else $error("wake without an armed flag");
endmodule : tic_wake_gate

// file: tic_controller.sv
// Two-source timer interrupt controller with control register and vectoring
`timescale 1ns/1ps
module tic_controller
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    // Data memory access to the control register
    input  wire logic [7:0]               regAddr,
    input  wire logic                     regWrEn,
    input  wire logic [7:0]               regWrData,
    output logic      [7:0]               regRdData,
    // Timer events
    input  wire logic                     timer0Overflow,
    input  wire logic                     timer1Overflow,
    // Core sequencing
    input  wire logic                     phaseTwoPulse,
    input  wire logic                     callInstr,
    input  wire logic                     irqReturnInstr,
    input  wire logic                     plainReturnInstr,
    input  wire logic                     haltEnter,
    input  wire logic [tic_pkg::PC_W-1:0] pcIn,
    // Answers to the core
    output logic                          irqAck,
    output logic      [7:0]               irqVector,
    output logic      [tic_pkg::PC_W-1:0] returnPc,
    output logic                          stackFull,
    output logic                          halted,
    output logic                          wakeUp
);
    import tic_pkg::*;

    tic_ctrl_t  ctrl_ff;
    tic_ctrl_t  nxt_ctrl;
    logic       ctrlWrite;
    logic       popReq;
    logic [1:0] ready;
    logic [1:0] src;
    logic       takeIrq;
    logic [7:0] ctrlImage;

    // Register decode and pops
    assign ctrlWrite = regWrEn && (regAddr == CTRL_OFS);
    assign popReq    = irqReturnInstr || plainReturnInstr;

    // Per-source readiness, enable gating the flag
    assign ready = {ctrl_ff.t1Flag & ctrl_ff.t1En,
                    ctrl_ff.t0Flag & ctrl_ff.t0En};
    assign src   = tic_pick(ready);

    // Decision only on the phase-two pulse; flags collected since the last one
    // A same-cycle call or return owns the stack, so the decision waits
    assign takeIrq = phaseTwoPulse
                     && ctrl_ff.globalEn
                     && !stackFull
                     && !callInstr
                     && !popReq
                     && (src != SRC_NONE);

    // Register image; unused bits stay zero
    always_comb
    begin
        ctrlImage = 8'h00;
        ctrlImage[GLOBAL_BIT] = ctrl_ff.globalEn;
        ctrlImage[T0E_BIT] = ctrl_ff.t0En;
        ctrlImage[T1E_BIT] = ctrl_ff.t1En;
        ctrlImage[T0FLAG_BIT] = ctrl_ff.t0Flag;
        ctrlImage[T1FLAG_BIT] = ctrl_ff.t1Flag;
    end

    // Next state: write, then return, then acknowledge, then hardware sets
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (ctrlWrite)
        begin
            nxt_ctrl.globalEn = regWrData[GLOBAL_BIT];
            nxt_ctrl.t0En = regWrData[T0E_BIT];
            nxt_ctrl.t1En = regWrData[T1E_BIT];
            nxt_ctrl.t0Flag = regWrData[T0FLAG_BIT];
            nxt_ctrl.t1Flag = regWrData[T1FLAG_BIT];
        end
        if (irqReturnInstr)
            nxt_ctrl.globalEn = 1'b1;
        if (takeIrq)
        begin
            nxt_ctrl.globalEn = 1'b0;
            if (src == SRC_T0)
                nxt_ctrl.t0Flag = 1'b0;
            else
                nxt_ctrl.t1Flag = 1'b0;
            nxt_ctrl.vector = tic_vector(src);
        end
        // Hardware set last, so an overflow is never lost to a clear
        if (timer0Overflow)
            nxt_ctrl.t0Flag = 1'b1;
        if (timer1Overflow)
            nxt_ctrl.t1Flag = 1'b1;
        nxt_ctrl.ackPulse = takeIrq;
        nxt_ctrl.rdData = (regAddr == CTRL_OFS) ? ctrlImage : 8'h00;
    end

    // Reset leaves every enable and flag clear
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff <= '0;
            ctrl_ff.rdData <= CTRL_RESET;
        end
        else
            ctrl_ff <= nxt_ctrl;
    end

    // Only the program counter is saved; the core restores nothing else
    tic_return_stack u_stack
    (
        .clock   (clock),
        .reset_n (reset_n),
        .push    (callInstr || takeIrq),
        .pushPc  (pcIn),
        .pop     (popReq),
        .topPc   (returnPc),
        .full    (stackFull)
    );

    // Wake sees the raw flags; enables do not matter for wake-up
    tic_wake_gate u_wake
    (
        .clock     (clock),
        .reset_n   (reset_n),
        .haltEnter (haltEnter),
        .flags     ({ctrl_ff.t1Flag, ctrl_ff.t0Flag}),
        .halted    (halted),
        .wakeUp    (wakeUp)
    );

    // Outputs to the core
    assign irqAck    = ctrl_ff.ackPulse;
    assign irqVector = ctrl_ff.vector;
    assign regRdData = ctrl_ff.rdData;

    // Checks

    chk_ack_clears_global: assert property (@(posedge clock) disable iff (!reset_n)
        takeIrq |=> !ctrl_ff.globalEn && irqAck)
        else $error("global enable still set after acknowledge");

    chk_ack_needs_global: assert property (@(posedge clock) disable iff (!reset_n)
        irqAck |-> $past(ctrl_ff.globalEn))
        else $error("acknowledge with global enable clear");

    chk_full_blocks: assert property (@(posedge clock) disable iff (!reset_n)
        irqAck |-> !$past(stackFull))
        else $error("acknowledge while stack full");

    chk_push_on_ack: assert property (@(posedge clock) disable iff (!reset_n)
        takeIrq && !stackFull |=> returnPc == $past(pcIn))
        else $error("program counter not pushed on acknowledge");

    chk_t0_sets: assert property (@(posedge clock) disable iff (!reset_n)
        timer0Overflow |=> ctrl_ff.t0Flag && regAddr != CTRL_OFS || ctrlImage[T0FLAG_BIT])
        else $error("timer 0 overflow did not set its flag");

    chk_t0_vector: assert property (@(posedge clock) disable iff (!reset_n)
        irqAck && irqVector == VEC_TIMER0 |-> $past(ctrl_ff.t0Flag) && $past(ctrl_ff.t0En))
        else $error("vector 08h without timer 0 request");

    chk_t1_vector: assert property (@(posedge clock) disable iff (!reset_n)
        irqAck && irqVector == VEC_TIMER1 |-> $past(ctrl_ff.t1Flag) && $past(ctrl_ff.t1En)
        && !($past(ctrl_ff.t0Flag) && $past(ctrl_ff.t0En)))
        else $error("vector 0ch taken wrongly");

    chk_flag_cleared: assert property (@(posedge clock) disable iff (!reset_n)
        takeIrq && src == SRC_T0 && !timer0Overflow |=> !ctrl_ff.t0Flag)
        else $error("serviced timer 0 flag not cleared");

    chk_irq_return_sets: assert property (@(posedge clock) disable iff (!reset_n)
        irqReturnInstr |=> ctrl_ff.globalEn)
        else $error("interrupt return did not set global enable");

    chk_plain_keeps_global: assert property (@(posedge clock) disable iff (!reset_n)
        plainReturnInstr && !irqReturnInstr && !ctrlWrite |=> ctrl_ff.globalEn == $past(ctrl_ff.globalEn))
        else $error("plain return changed global enable");

    chk_phase_only: assert property (@(posedge clock) disable iff (!reset_n)
        irqAck |-> $past(phaseTwoPulse))
        else $error("acknowledge outside a phase-two pulse");

    chk_priority: assert property (@(posedge clock) disable iff (!reset_n)
        takeIrq && ready == 2'b11 && !ctrlWrite |=> irqVector == VEC_TIMER0 && ctrl_ff.t1Flag)
        else $error("timer 1 served before timer 0");

    chk_flag_holds: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl_ff.t1Flag && !takeIrq && !ctrlWrite |=> ctrl_ff.t1Flag)
        else $error("timer 1 flag dropped on its own");

    chk_unused_zero: assert property (@(posedge clock) disable iff (!reset_n)
        (regRdData & ~CTRL_USED) == 8'h00)
        else $error("unused control bits read nonzero");

    chk_set_wins: assert property (@(posedge clock) disable iff (!reset_n)
        timer1Overflow && ctrlWrite && !regWrData[T1FLAG_BIT] |=> ctrl_ff.t1Flag)
        else $error("software clear beat timer 1 overflow");

    chk_read_back: assert property (@(posedge clock) disable iff (!reset_n)
        ctrlWrite && !timer0Overflow && !timer1Overflow && !takeIrq && !irqReturnInstr
        ##1 regAddr == CTRL_OFS |=> regRdData == ($past(regWrData, 2) & CTRL_USED))
        else $error("control register read back mismatch");

    // Flag checks; the hardware set must survive every clear
    chk_t1_sets: assert property (@(posedge clock) disable iff (!reset_n)
        timer1Overflow |=> ctrl_ff.t1Flag)
        else $error("timer 1 overflow did not set its flag");

    chk_t1_cleared: assert property (@(posedge clock) disable iff (!reset_n)
        takeIrq && src == SRC_T1 && !timer1Overflow |=> !ctrl_ff.t1Flag)
        else $error("serviced timer 1 flag not cleared");

    chk_t0_holds: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl_ff.t0Flag && !takeIrq && !ctrlWrite |=> ctrl_ff.t0Flag)
        else $error("timer 0 flag dropped on its own");

    chk_t0_set_wins: assert property (@(posedge clock) disable iff (!reset_n)
        timer0Overflow && ctrlWrite && !regWrData[T0FLAG_BIT] |=> ctrl_ff.t0Flag)
        else $error("software clear beat timer 0 overflow");

    chk_set_beats_ack: assert property (@(posedge clock) disable iff (!reset_n)
        timer0Overflow && takeIrq |=> ctrl_ff.t0Flag)
        else $error("acknowledge clear beat timer 0 overflow");

    // Enable checks
    chk_global_write_set: assert property (@(posedge clock) disable iff (!reset_n)
        ctrlWrite && regWrData[GLOBAL_BIT] && !takeIrq |=> ctrl_ff.globalEn)
        else $error("global enable write of one lost");

    chk_global_write_clr: assert property (@(posedge clock) disable iff (!reset_n)
        ctrlWrite && !regWrData[GLOBAL_BIT] && !irqReturnInstr |=> !ctrl_ff.globalEn)
        else $error("global enable write of zero lost");

    chk_t0_enable_set: assert property (@(posedge clock) disable iff (!reset_n)
        ctrlWrite && regWrData[T0E_BIT] |=> ctrl_ff.t0En)
        else $error("timer 0 enable not set");

    chk_t0_enable_clr: assert property (@(posedge clock) disable iff (!reset_n)
        ctrlWrite && !regWrData[T0E_BIT] |=> !ctrl_ff.t0En)
        else $error("timer 0 enable not cleared");

    chk_t1_enable_set: assert property (@(posedge clock) disable iff (!reset_n)
        ctrlWrite && regWrData[T1E_BIT] |=> ctrl_ff.t1En)
        else $error("timer 1 enable not set");

    chk_enables_hold: assert property (@(posedge clock) disable iff (!reset_n)
        !ctrlWrite |=> $stable(ctrl_ff.t0En) && $stable(ctrl_ff.t1En))
        else $error("source enable changed without a write");

    // Acknowledge checks
    chk_ack_one_cycle: assert property (@(posedge clock) disable iff (!reset_n)
        irqAck |=> !irqAck)
        else $error("acknowledge longer than one cycle");

    chk_call_blocks_ack: assert property (@(posedge clock) disable iff (!reset_n)
        callInstr |=> !irqAck)
        else $error("acknowledge in a call cycle");

    chk_pop_blocks_ack: assert property (@(posedge clock) disable iff (!reset_n)
        popReq |=> !irqAck)
        else $error("acknowledge in a return cycle");

    chk_ack_has_vector: assert property (@(posedge clock) disable iff (!reset_n)
        irqAck |-> irqVector == VEC_TIMER0 || irqVector == VEC_TIMER1)
        else $error("acknowledge with unknown vector");

    chk_vector_holds: assert property (@(posedge clock) disable iff (!reset_n)
        !irqAck |-> $stable(irqVector))
        else $error("vector changed without acknowledge");

    chk_disabled_no_ack: assert property (@(posedge clock) disable iff (!reset_n)
        !ctrl_ff.t0En && !ctrl_ff.t1En |=> !irqAck)
        else $error("acknowledge with both sources disabled");

    chk_t0_taken: assert property (@(posedge clock) disable iff (!reset_n)
        phaseTwoPulse && ctrl_ff.globalEn && !stackFull && !callInstr && !popReq && ready[0]
        |=> irqAck && irqVector == VEC_TIMER0)
        else $error("timer 0 request not taken");

    chk_t1_taken: assert property (@(posedge clock) disable iff (!reset_n)
        phaseTwoPulse && ctrl_ff.globalEn && !stackFull && !callInstr && !popReq && ready == 2'b10
        |=> irqAck && irqVector == VEC_TIMER1)
        else $error("timer 1 request not taken");

    chk_full_takes_none: assert property (@(posedge clock) disable iff (!reset_n)
        stackFull |=> !irqAck)
        else $error("acknowledge after stack full");

    chk_pop_frees_level: assert property (@(posedge clock) disable iff (!reset_n)
        stackFull && popReq && !callInstr |=> !stackFull)
        else $error("return did not free a level");

    // Read path checks
    chk_unmapped_read: assert property (@(posedge clock) disable iff (!reset_n)
        regAddr != CTRL_OFS |=> regRdData == 8'h00)
        else $error("unmapped address read nonzero");

    chk_image_read: assert property (@(posedge clock) disable iff (!reset_n)
        regAddr == CTRL_OFS |=> regRdData == $past(ctrlImage))
        else $error("control read differs from register state");
endmodule : tic_controller

// file: tic_core_model.sv
// Core sequencer model: phase-two pulses and a running program counter
`timescale 1ns/1ps
module tic_core_model
(
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    // Control from the bench
    input  wire logic                     p2En,
    // To the controller
    output logic                          phaseTwoPulse,
    output logic      [tic_pkg::PC_W-1:0] pcIn
);
    import tic_pkg::*;
    logic [1:0] phase;
    // Pulse every fourth cycle, moved off the rising edge; issues no calls of its own
    always @(negedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase         <= 2'h0;
            phaseTwoPulse <= 1'b0;
            pcIn          <= 15'h0100;
        end
        else
        begin
            phase         <= phase + 2'h1;
            phaseTwoPulse <= p2En && (phase == 2'h3);
            // Only the counter reaches the stack; a routine saves the rest itself
            pcIn          <= pcIn + 15'h0001;
        end
    end
endmodule : tic_core_model

// file: tic_controller_tb.sv
// Self-checking bench for the timer interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tic_controller_tb;
    import tic_pkg::*;
    logic            clock, reset_n, regWrEn, timer0Overflow, timer1Overflow, callInstr;
    logic            irqReturnInstr, plainReturnInstr, haltEnter, p2En, phaseTwoPulse;
    logic            irqAck, stackFull, halted, wakeUp, ok;
    logic [7:0]      regAddr, regWrData, regRdData, irqVector, rd;
    logic [PC_W-1:0] pcIn, returnPc;
    int              num_errors = 0, checks = 0, cycles = 0;

    tic_controller tic_controller_inst
    (
        .clock, .reset_n, .regAddr, .regWrEn, .regWrData, .regRdData,
        .timer0Overflow, .timer1Overflow, .phaseTwoPulse, .callInstr, .irqReturnInstr,
        .plainReturnInstr, .haltEnter, .pcIn, .irqAck, .irqVector, .returnPc,
        .stackFull, .halted, .wakeUp
    );
    tic_core_model tic_core_model_inst
    (
        .clock, .reset_n, .p2En, .phaseTwoPulse, .pcIn
    );

    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // Sample just after the rising edge, once registers have settled
    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick

    task automatic do_reset();
        @(negedge clock);
        reset_n = 1'b0;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clock);
        regWrEn = 1'b0;
    endtask : wr

    // Read data is registered, so it shows one edge after the address
    task automatic rdreg(input logic [7:0] a);
        @(negedge clock);
        regAddr = a;
        tick();
        rd = regRdData;
    endtask : rdreg

    // One-cycle pulse on one core or timer event line
    task automatic strobe(input int k);
        @(negedge clock);
        {haltEnter, plainReturnInstr, irqReturnInstr, callInstr, timer1Overflow, timer0Overflow} = 6'h01 << k;
        @(negedge clock);
        {haltEnter, plainReturnInstr, irqReturnInstr, callInstr, timer1Overflow, timer0Overflow} = 6'h00;
    endtask : strobe

    // Bounded wait for acknowledge (sel 0) or wake (sel 1)
    task automatic wait_evt(input logic sel, input int n);
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++)
        begin
            tick();
            ok = sel ? wakeUp : irqAck;
        end
    endtask : wait_evt

    task automatic test_reset();
        rdreg(CTRL_OFS);
        `CHK("control after reset", 8'h00, rd)
        `CHK("vector after reset", 8'h00, irqVector)
        `CHK("full after reset", 1'b0, stackFull)
    endtask : test_reset

    task automatic test_regs();
        wr(CTRL_OFS, 8'hff);
        rdreg(CTRL_OFS);
        `CHK("control image", 8'h6d, rd)
        wr(8'h0c, 8'h00);
        rdreg(CTRL_OFS);
        `CHK("foreign write ignored", 8'h6d, rd)
        rdreg(8'h0c);
        `CHK("unmapped read", 8'h00, rd)
        wr(CTRL_OFS, 8'h00);
        rdreg(CTRL_OFS);
        `CHK("software clear", 8'h00, rd)
    endtask : test_regs

    task automatic test_timer0();
        wr(CTRL_OFS, 8'h04);
        p2En <= 1'b1;
        strobe(0);
        wait_evt(1'b0, 12);
        `CHK("no ack with global off", 1'b0, ok)
        rdreg(CTRL_OFS);
        `CHK("timer0 flag set", 8'h24, rd)
        wr(CTRL_OFS, 8'h25);
        wait_evt(1'b0, 6);
        `CHK("ack at next phase pulse", 1'b1, ok)
        `CHK("timer0 vector", VEC_TIMER0, irqVector)
        `CHK("pushed pc", pcIn, returnPc)
        tick();
        `CHK("single ack", 1'b0, irqAck)
        rdreg(CTRL_OFS);
        `CHK("flag and global cleared", 8'h04, rd)
    endtask : test_timer0

    task automatic test_priority();
        wr(CTRL_OFS, 8'h6d);
        wait_evt(1'b0, 6);
        `CHK("ack both pending", 1'b1, ok)
        `CHK("timer0 first", VEC_TIMER0, irqVector)
        rdreg(CTRL_OFS);
        `CHK("timer1 still pending", 8'h4c, rd)
        strobe(3);
        wait_evt(1'b0, 6);
        `CHK("ack after irq return", 1'b1, ok)
        `CHK("timer1 vector", VEC_TIMER1, irqVector)
        strobe(4);
        rdreg(CTRL_OFS);
        `CHK("plain return keeps global off", 8'h0c, rd)
    endtask : test_priority

    // Stack full holds the request back until a return frees a level
    task automatic test_stack();
        p2En <= 1'b0;
        do_reset();
        repeat (7) strobe(2);
        `CHK("not full at seven", 1'b0, stackFull)
        strobe(2);
        `CHK("full at eight", 1'b1, stackFull)
        wr(CTRL_OFS, 8'h25);
        p2En <= 1'b1;
        wait_evt(1'b0, 12);
        `CHK("ack withheld when full", 1'b0, ok)
        strobe(4);
        wait_evt(1'b0, 6);
        `CHK("ack after pop", 1'b1, ok)
        // A call on a full stack drops the oldest level and stays full
        strobe(2);
        `CHK("full after overflow push", 1'b1, stackFull)
    endtask : test_stack

    // No phase pulses in halt, as the core would behave
    task automatic test_halt();
        p2En <= 1'b0;
        do_reset();
        strobe(5);
        `CHK("halted", 1'b1, halted)
        @(negedge clock);
        timer1Overflow = 1'b1;
        wait_evt(1'b1, 4);
        `CHK("timer1 wakes", 1'b1, ok)
        @(negedge clock);
        timer1Overflow = 1'b0;
        `CHK("awake", 1'b0, halted)
        wr(CTRL_OFS, 8'h20);
        strobe(5);
        strobe(0);
        wait_evt(1'b1, 8);
        `CHK("preset flag cannot wake", 1'b0, ok)
    endtask : test_halt

    // Overflow and software clear in one cycle: the set must win
    task automatic test_set_clear();
        @(negedge clock);
        regAddr = CTRL_OFS;
        regWrData = 8'h00;
        regWrEn = 1'b1;
        timer0Overflow = 1'b1;
        @(negedge clock);
        regWrEn = 1'b0;
        timer0Overflow = 1'b0;
        rdreg(CTRL_OFS);
        `CHK("set beats clear", 8'h20, rd)
    endtask : test_set_clear

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard, far above the fewer than two hundred cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            complete_run();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        p2En = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        {haltEnter, plainReturnInstr, irqReturnInstr, callInstr, timer1Overflow, timer0Overflow} = 6'h00;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        test_reset();
        test_regs();
        test_timer0();
        test_priority();
        test_stack();
        test_halt();
        test_set_clear();
        complete_run();
    end
endmodule : tic_controller_tb
